// File: rtl/pdt_defines.svh
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// ------------------------------------------------------------
// Register map and fields.
// ------------------------------------------------------------
`define PDT_OFF_CTRL 8'h00
`define PDT_OFF_COUNT 8'h04
`define PDT_OFF_STAT 8'h08
`define PDT_OFF_CLR 8'h0c
`define PDT_OFF_EN 8'h10
`define PDT_FLAG_BIT 7
`define PDT_MASK_BIT 6
`define PDT_EVT_BIT 0
`define PDT_CTRL_ONES 6'h3f
`define PDT_COUNT_RST 8'hff
`define PDT_PRESC_RST 7'h7f
`define PDT_COUNT_ONE 8'h01
`define PDT_COUNT_ZERO 8'h00
`define PDT_VEC_TIMER 11'h7f8
`define PDT_VEC_NONE 11'h000
`define PDT_RESP_OKAY 2'h0
`define PDT_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Timing.
// ------------------------------------------------------------
`define PDT_CLK_NS 25
`define PDT_MACHINE_CYCLE_NS 100
`define PDT_RST_LOW_CYC \
   ((`PDT_MACHINE_CYCLE_NS + `PDT_CLK_NS - 1) / `PDT_CLK_NS)
`define PDT_MC_LAST 2'h3
`define PDT_RST_CNT_MAX 3'h7

`endif

// File: rtl/pdt_pkg.sv
`default_nettype none

package pdt_pkg;
   typedef enum logic [2:0] {
      PDT_SRC_PIN = 3'b001,
      PDT_SRC_MCLK = 3'b010,
      PDT_SRC_MCLK_GATED = 3'b100
   } pdt_src_type;
endpackage

`default_nettype wire

// File: rtl/pdt_pin_sync.sv
`default_nettype none

// ------------------------------------------------------------
// Three-stage pin synchroniser with re-arming edge detect.
// ------------------------------------------------------------
module pdt_pin_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic level,
   output logic rise
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A rise counts only after a stable low has been seen.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level <= RST_VAL;
         rise <= 1'b0;
      end else begin
         rise <= (s2_r == s3_r) && s3_r && !level;
         if (s2_r == s3_r) begin
            level <= s3_r;
         end
      end
   end
endmodule // pdt_pin_sync

`default_nettype wire

// File: rtl/pdt_timer.sv
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "pdt_defines.svh"
`default_nettype none

module pdt_timer #(
   parameter pdt_pkg::pdt_src_type SRC = pdt_pkg::PDT_SRC_MCLK,
   parameter int unsigned PRESC_LOG2 = 0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic timer_pin,
   input wire logic reset_pin_n,
   input wire logic low_volt_det,
   input wire logic cpu_int_mask,
   output logic cpu_timer_req,
   output logic [10:0] vector_addr,
   output logic irq
);
   import pdt_pkg::*;

   localparam logic [6:0] PRESC_SEL = 7'((1 << PRESC_LOG2) - 1);
   localparam logic [2:0] RST_LOW_LIM = 3'(`PDT_RST_LOW_CYC);

   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_strb0_r;
   logic [1:0] mc_div_r;
   logic mc_tick;
   logic pin_level;
   logic pin_rise;
   logic rst_level;
   logic lvd_level;
   logic [2:0] rst_low_cnt_r;
   logic int_rst_r;
   logic tmr_rst;
   logic src_pulse;
   logic [6:0] presc_r;
   logic count_tick;
   logic [7:0] count_r;
   logic flag_r;
   logic mask_r;
   logic irq_en_r;
   logic wr_do;
   logic wr_hit;
   logic ld_cnt;
   logic sw_clr;
   logic zero_evt;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == `PDT_OFF_CTRL) || (a == `PDT_OFF_COUNT) ||
         (a == `PDT_OFF_STAT) || (a == `PDT_OFF_CLR) ||
         (a == `PDT_OFF_EN);
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------
   pdt_pin_sync #(.RST_VAL(1'b0)) u_timer_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(timer_pin),
      .level(pin_level),
      .rise(pin_rise)
   );

   pdt_pin_sync #(.RST_VAL(1'b1)) u_reset_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(reset_pin_n),
      .level(rst_level),
      .rise()
   );

   pdt_pin_sync #(.RST_VAL(1'b0)) u_lvd_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(low_volt_det),
      .level(lvd_level),
      .rise()
   );

   // ------------------------------------------------------------
   // Machine clock and internal reset.
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mc_div_r <= 2'h0;
      end else begin
         mc_div_r <= mc_div_r + 2'h1;
      end
   end

   assign mc_tick = (mc_div_r == `PDT_MC_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_low_cnt_r <= 3'h0;
      end else if (rst_level) begin
         rst_low_cnt_r <= 3'h0;
      end else if (rst_low_cnt_r != `PDT_RST_CNT_MAX) begin
         rst_low_cnt_r <= rst_low_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_rst_r <= 1'b0;
      end else begin
         int_rst_r <= (rst_low_cnt_r > RST_LOW_LIM) || lvd_level;
      end
   end

   assign tmr_rst = !aresetn || int_rst_r;

   // ------------------------------------------------------------
   // Clock source and prescaler.
   // ------------------------------------------------------------
   always_comb begin
      case (SRC)
         PDT_SRC_PIN: src_pulse = pin_rise;
         PDT_SRC_MCLK: src_pulse = mc_tick;
         PDT_SRC_MCLK_GATED: src_pulse = mc_tick && pin_level;
         default: src_pulse = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (tmr_rst) begin
         presc_r <= `PDT_PRESC_RST;
      end else if (src_pulse) begin
         presc_r <= presc_r - 7'h01;
      end
   end

   assign count_tick = src_pulse && ((presc_r & PRESC_SEL) == 7'h00);

   // ------------------------------------------------------------
   // Counter and request flag.
   // ------------------------------------------------------------
   assign wr_do = !awready && !wready && !bvalid;
   assign wr_hit = wr_do && w_strb0_r;
   assign ld_cnt = wr_hit && (aw_addr_r == `PDT_OFF_COUNT);
   assign sw_clr = wr_hit && (((aw_addr_r == `PDT_OFF_CTRL) && !w_data_r[`PDT_FLAG_BIT]) ||
      ((aw_addr_r == `PDT_OFF_CLR) && w_data_r[`PDT_EVT_BIT]));
   assign zero_evt = count_tick && !ld_cnt && (count_r == `PDT_COUNT_ONE);

   always_ff @(posedge aclk) begin
      if (tmr_rst) begin
         count_r <= `PDT_COUNT_RST;
      end else if (ld_cnt) begin
         count_r <= w_data_r;
      end else if (count_tick) begin
         count_r <= count_r - 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (tmr_rst) begin
         flag_r <= 1'b0;
      end else if (zero_evt) begin
         flag_r <= 1'b1;
      end else if (sw_clr) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (tmr_rst) begin
         mask_r <= 1'b1;
      end else if (wr_hit && (aw_addr_r == `PDT_OFF_CTRL)) begin
         mask_r <= w_data_r[`PDT_MASK_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_r <= 1'b0;
      end else if (wr_hit && (aw_addr_r == `PDT_OFF_EN)) begin
         irq_en_r <= w_data_r[`PDT_EVT_BIT];
      end
   end

   // ------------------------------------------------------------
   // Interrupt outputs.
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (tmr_rst) begin
         cpu_timer_req <= 1'b0;
         vector_addr <= `PDT_VEC_NONE;
         irq <= 1'b0;
      end else begin
         cpu_timer_req <= flag_r && !mask_r && !cpu_int_mask;
         vector_addr <= (flag_r && !mask_r) ? `PDT_VEC_TIMER : `PDT_VEC_NONE;
         irq <= flag_r && irq_en_r;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channels.
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         aw_addr_r <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_addr_r <= awaddr;
      end else if (wr_do) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b1;
         w_data_r <= 8'h00;
         w_strb0_r <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_data_r <= wdata[7:0];
         w_strb0_r <= wstrb[0];
      end else if (wr_do) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `PDT_RESP_OKAY;
      end else if (wr_do) begin
         bvalid <= 1'b1;
         bresp <= addr_ok(aw_addr_r) ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channels.
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `PDT_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= addr_ok(araddr) ? `PDT_RESP_OKAY : `PDT_RESP_SLVERR;
         case (araddr)
            `PDT_OFF_CTRL: rdata <= {24'h00_0000, flag_r, mask_r, `PDT_CTRL_ONES};
            `PDT_OFF_COUNT: rdata <= {24'h00_0000, count_r};
            `PDT_OFF_STAT: rdata <= {31'h0000_0000, flag_r};
            `PDT_OFF_EN: rdata <= {31'h0000_0000, irq_en_r};
            default: rdata <= 32'h0000_0000;
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_reset_load;
      int_rst_r |=> (count_r == `PDT_COUNT_RST) && (presc_r == `PDT_PRESC_RST)
         && !flag_r && mask_r;
   endproperty
   a_reset_load: assert property (p_reset_load)
      else $error("Reset did not load timer state.");

   property p_decrement;
      (count_tick && !ld_cnt && !tmr_rst) |=> (count_r == $past(count_r) - 8'h01);
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("Counter did not decrement by one.");

   property p_wrap;
      (count_tick && !ld_cnt && !tmr_rst && count_r == `PDT_COUNT_ZERO)
         |=> (count_r == `PDT_COUNT_RST);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Counter did not wrap to all ones.");

   property p_flag_set;
      (zero_evt && !tmr_rst) |=> flag_r ##1 ($past(tmr_rst) || irq == $past(irq_en_r));
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Zero count did not set the request flag.");

   property p_flag_sticky;
      (flag_r && !sw_clr && !tmr_rst) |=> flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("Request flag dropped without a clear.");

   property p_masked;
      mask_r |=> !cpu_timer_req;
   endproperty
   a_masked: assert property (p_masked)
      else $error("Masked timer raised a request.");

   property p_global_mask;
      (cpu_int_mask && flag_r && !sw_clr && !tmr_rst) |=> !cpu_timer_req && flag_r;
   endproperty
   a_global_mask: assert property (p_global_mask)
      else $error("Global mask did not hold the request.");

   property p_reset_pin;
      (rst_low_cnt_r > RST_LOW_LIM) |=> int_rst_r;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("Long reset pin low did not reset.");

   property p_machine_tick;
      mc_tick |=> !mc_tick [*3] ##1 mc_tick;
   endproperty
   a_machine_tick: assert property (p_machine_tick)
      else $error("Machine tick spacing is not four.");

   property p_gate;
      (SRC == PDT_SRC_MCLK_GATED && !pin_level && !tmr_rst) |=> (presc_r == $past(presc_r));
   endproperty
   a_gate: assert property (p_gate)
      else $error("Gated source passed a tick while low.");
endmodule // pdt_timer

`default_nettype wire

// File: dv/pdt_cpu_model.sv
`default_nettype none

// ------------------------------------------------------------
// CPU core and timer pin model.
// ------------------------------------------------------------
module pdt_cpu_model (
   input wire logic aclk,
   input wire logic pin_cmd,
   input wire logic imask_cmd,
   input wire logic cpu_timer_req,
   input wire logic [10:0] vector_addr,
   output logic timer_pin,
   output logic cpu_int_mask,
   output logic [10:0] taken_vec
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      timer_pin = 1'b0;
      cpu_int_mask = 1'b0;
      taken_vec = 11'h000;
   end
   // The pin level is held for at least 10 clocks (two and a half machine cycles) between changes.
   always @(posedge aclk) begin
      timer_pin <= pin_cmd;
      cpu_int_mask <= imask_cmd;
      if (cpu_timer_req === 1'b1 && cpu_int_mask === 1'b0) begin
         taken_vec <= vector_addr;
      end
   end
endmodule // pdt_cpu_model

`default_nettype wire

// File: dv/prescaled_down_timer_bench.sv
`include "pdt_defines.svh"
`default_nettype none

// ------------------------------------------------------------
// Self-checking bench.
// ------------------------------------------------------------
module prescaled_down_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic reset_pin_n, low_volt_det, pin_cmd, imask_cmd;
   logic timer_pin, cpu_int_mask, cpu_timer_req, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, c0, rdata_p, dp;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [10:0] vector_addr, taken_vec;
   int num_errors, n_checks, cyc;

   pdt_timer #(.SRC(pdt_pkg::PDT_SRC_MCLK_GATED), .PRESC_LOG2(1)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .timer_pin(timer_pin),
      .reset_pin_n(reset_pin_n), .low_volt_det(low_volt_det),
      .cpu_int_mask(cpu_int_mask), .cpu_timer_req(cpu_timer_req),
      .vector_addr(vector_addr), .irq(irq));
   pdt_timer #(.SRC(pdt_pkg::PDT_SRC_PIN), .PRESC_LOG2(0)) u_pin (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(), .bresp(), .bvalid(), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdata_p),
      .rresp(), .rvalid(), .rready(rready), .timer_pin(timer_pin),
      .reset_pin_n(reset_pin_n), .low_volt_det(low_volt_det),
      .cpu_int_mask(cpu_int_mask), .cpu_timer_req(),
      .vector_addr(), .irq());
   pdt_cpu_model u_cpu (.aclk(aclk), .pin_cmd(pin_cmd), .imask_cmd(imask_cmd),
      .cpu_timer_req(cpu_timer_req), .vector_addr(vector_addr),
      .timer_pin(timer_pin), .cpu_int_mask(cpu_int_mask), .taken_vec(taken_vec));

   task automatic tally_and_finish;
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      if (got !== exp) begin
         $display("BAD %0t got %h expected %h", $time, got, exp);
         num_errors++;
      end
      n_checks++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      dp = rdata_p;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic t_reset_vals;
      rd(`PDT_OFF_CTRL);
      chk(d, 32'h0000007f);
      rd(`PDT_OFF_COUNT);
      chk(d, 32'h000000ff);
   endtask
   task automatic t_rate(input logic pin, input logic [7:0] steps);
      pin_cmd <= pin;
      repeat (8) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      c0 = d;
      repeat (77) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      chk(d, {24'h0, c0[7:0] - steps});
   endtask
   task automatic t_zero;
      int i;
      pin_cmd <= 1'b1;
      wr(`PDT_OFF_COUNT, 32'h00000003);
      rd(`PDT_OFF_COUNT);
      chk({31'h0, d === 32'h3 || d === 32'h2}, 32'h1);
      d = 32'h0000_0000;
      for (i = 0; i < 30 && d[0] !== 1'b1; i++) rd(`PDT_OFF_STAT);
      chk(d, 32'h00000001);
      repeat (40) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      chk({31'h0, d[7:0] > 8'hf0}, 32'h1);
      rd(`PDT_OFF_CTRL);
      chk(d, 32'h000000ff);
   endtask
   task automatic t_pin_edges;
      int i;
      pin_cmd <= 1'b0;
      repeat (12) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      c0 = dp;
      for (i = 0; i < 4; i++) begin
         pin_cmd <= 1'b1;
         repeat (10) @(posedge aclk);
         pin_cmd <= 1'b0;
         repeat (10) @(posedge aclk);
      end
      rd(`PDT_OFF_COUNT);
      chk(dp, {24'h0, c0[7:0] - 8'h04});
   endtask
   task automatic t_irq;
      chk({31'h0, cpu_timer_req}, 32'h0);
      wr(`PDT_OFF_CTRL, 32'h00000080);
      repeat (3) @(posedge aclk);
      chk({31'h0, cpu_timer_req}, 32'h1);
      chk({21'h0, taken_vec}, 32'h000007f8);
      imask_cmd <= 1'b1;
      repeat (4) @(posedge aclk);
      chk({31'h0, cpu_timer_req}, 32'h0);
      imask_cmd <= 1'b0;
      repeat (4) @(posedge aclk);
      chk({31'h0, cpu_timer_req}, 32'h1);
      wr(`PDT_OFF_EN, 32'h00000001);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(`PDT_OFF_EN, 32'h00000000);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      wr(`PDT_OFF_EN, 32'h00000001);
      wr(`PDT_OFF_CLR, 32'h00000001);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rd(`PDT_OFF_STAT);
      chk(d, 32'h00000000);
      wr(8'h14, 32'h00000001);
      chk({30'h0, r}, {30'h0, `PDT_RESP_SLVERR});
      rd(8'h14);
      chk({30'h0, r}, {30'h0, `PDT_RESP_SLVERR});
   endtask
   task automatic t_rst_pin;
      pin_cmd <= 1'b0;
      wr(`PDT_OFF_COUNT, 32'h00000005);
      wr(`PDT_OFF_CTRL, 32'h00000000);
      reset_pin_n <= 1'b0;
      repeat (3) @(posedge aclk);
      reset_pin_n <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      chk(d, 32'h00000005);
      wstrb <= 4'he;
      wr(`PDT_OFF_COUNT, 32'h00000022);
      wstrb <= 4'hf;
      chk({30'h0, r}, {30'h0, `PDT_RESP_OKAY});
      rd(`PDT_OFF_COUNT);
      chk(d, 32'h00000005);
      reset_pin_n <= 1'b0;
      repeat (12) @(posedge aclk);
      reset_pin_n <= 1'b1;
      repeat (10) @(posedge aclk);
      rd(`PDT_OFF_CTRL);
      chk(d, 32'h0000007f);
      rd(`PDT_OFF_COUNT);
      chk(d, 32'h000000ff);
      wr(`PDT_OFF_COUNT, 32'h00000005);
      low_volt_det <= 1'b1;
      repeat (6) @(posedge aclk);
      low_volt_det <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(`PDT_OFF_COUNT);
      chk(d, 32'h000000ff);
   endtask

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, low_volt_det, imask_cmd} = '0;
      {aresetn, pin_cmd} = 2'b00;
      reset_pin_n = 1'b1;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_vals();
      t_rate(1'b1, 8'd10);
      t_rate(1'b0, 8'd0);
      t_zero();
      t_irq();
      t_pin_edges();
      t_rst_pin();
      tally_and_finish();
   end
endmodule // prescaled_down_timer_bench

`default_nettype wire
